// file: hdl/lgm_defs.svh
/*
  constants for the legacy mode compatibility block: register offsets,
  field positions, reset values and alias encodings.
  assumes inclusion once per compile unit; the guard handles repeats.
*/
`ifndef LGM_DEFS_SVH
`define LGM_DEFS_SVH
// register byte offsets
`define LGM_OFF_CTRL 12'h000
`define LGM_OFF_SEGBASE 12'h004
`define LGM_OFF_STATUS 12'h008
// control field positions
`define LGM_CTRL_LEGACY 0
`define LGM_CTRL_VM 1
`define LGM_CTRL_PE 2
`define LGM_CTRL_CSIZE 3
`define LGM_CTRL_SBIG 4
`define LGM_CTRL_AOVR 5
`define LGM_CTRL_BIGEND 6
`define LGM_CTRL_TOP_LO 8
`define LGM_CTRL_TOP_HI 10
`define LGM_CTRL_RST 32'h0000_0000
`define LGM_SEG_RST 32'h0000_0000
// alias encodings
`define LGM_PK_BASE 5'h08
`define LGM_VEC_BASE 5'h10
`define LGM_PK_SE 18'h3FFFF
`define LGM_VEC_SE 18'h1003E
// axi responses
`define LGM_RESP_OKAY 2'h0
`define LGM_RESP_SLVERR 2'h2
`endif

// file: hdl/lgm_pkg.sv
/*
  types for the legacy mode compatibility block.
  assumes lgm_defs.svh supplies the numbers.
*/
package lgm_pkg;
  // one aliased floating-point register write
  typedef struct packed {
    logic en;
    logic [4:0] idx;
    logic [81:0] val;
  } lgm_fpw_t;
  // ordering attributes of one memory access
  typedef struct packed {
    logic acq;
    logic rel;
    logic fence;
  } lgm_mord_t;
  // segmentation regime, one-hot
  typedef enum logic [3:0] {
    LGM_SEG_NATIVE = 4'h1,
    LGM_SEG_REAL = 4'h2,
    LGM_SEG_V86 = 4'h4,
    LGM_SEG_PROT = 4'h8
  } lgm_seg_t;
endpackage : lgm_pkg

// file: hdl/lgm_compat.sv
/*
  legacy mode compatibility: register aliasing, legacy address forming,
  byte order, instruction cache coherence hints and access ordering.
  assumes synchronous inputs on core_clk, an axi4-lite master for control,
  and a native pipeline that honours the acquire/release/fence marks.
*/
`timescale 1ns/100ps
`include "lgm_defs.svh"
module lgm_compat import lgm_pkg::*; #(
  parameter int ADDR_W = 12
) (
  input wire logic core_clk,
  input wire logic rst_n,
  // axi4-lite slave
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // native floating-point writes and reads
  input wire lgm_fpw_t nativeFpWr,
  input wire logic [4:0] nativeRdIdx,
  output logic [81:0] nativeRdData,
  // legacy packed and vector register ports
  input wire logic pkWrEn,
  input wire logic [2:0] pkWrIdx,
  input wire logic [63:0] pkWrData,
  input wire logic [2:0] pkRdIdx,
  output logic [63:0] pkRdData,
  input wire logic [2:0] stRdIdx,
  output logic [63:0] stRdData,
  input wire logic vecWrEn,
  input wire logic [2:0] vecWrIdx,
  input wire logic [127:0] vecWrData,
  input wire logic [2:0] vecRdIdx,
  output logic [127:0] vecRdData,
  output lgm_fpw_t fpWrLo,
  output lgm_fpw_t fpWrHi,
  // address generation
  input wire logic agReq,
  input wire logic agFetch,
  input wire logic [31:0] agBase,
  input wire logic [31:0] agIndex,
  input wire logic [1:0] agScale,
  input wire logic [31:0] agDisp,
  input wire logic [31:0] agIp,
  input wire logic [3:0] agLen,
  input wire logic [63:0] agNative,
  output logic agValid,
  output logic [63:0] agVa,
  output logic [63:0] agEndVa,
  output logic [16:0] agEndEa,
  // memory access marking
  input wire logic memReq,
  input wire logic memLoad,
  input wire logic memStore,
  input wire logic memLocked,
  input wire logic memFenceReq,
  input wire logic [63:0] memWrData,
  input wire logic [63:0] memAddr,
  output logic memValid,
  output lgm_mord_t memOrd,
  output logic [63:0] memBusData,
  output logic icacheInval,
  output logic [63:0] icacheInvalAddr,
  output logic icacheSync
);
  // control and segment base registers
  logic [31:0] ctrl_r;
  logic [31:0] segBase_r;
  logic legacyPrev_r;
  // shadow of the aliased floating-point file
  logic [81:0] fpFile [0:31];
  // axi write and read side holding registers
  logic awHeld_r;
  logic wHeld_r;
  logic [ADDR_W-1:0] awAddr_r;
  logic [31:0] wData_r;
  logic [3:0] wStrb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  // decoded control fields
  logic legacy;
  logic [2:0] topOfStack;
  lgm_seg_t segMode;
  logic size32;
  logic [31:0] eaSum;
  logic [31:0] eaStart;
  logic [31:0] vaStart;
  logic [2:0] stPhys;

  // refuse address widths too narrow for the register map
  if (ADDR_W < 4) begin : g_addr_w_chk
    $error("ADDR_W too small for register map");
  end

  assign legacy = ctrl_r[`LGM_CTRL_LEGACY];
  assign topOfStack = ctrl_r[`LGM_CTRL_TOP_HI:`LGM_CTRL_TOP_LO];

  // axi handshakes; write address and data taken in either order
  assign s_axi_awready = !awHeld_r && !bvalid_r;
  assign s_axi_wready = !wHeld_r && !bvalid_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  // write channel capture and response
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      awHeld_r <= 1'b0;
      wHeld_r <= 1'b0;
      awAddr_r <= '0;
      wData_r <= '0;
      wStrb_r <= '0;
      bvalid_r <= 1'b0;
      bresp_r <= `LGM_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_r <= 1'b1;
        awAddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_r <= 1'b1;
        wData_r <= s_axi_wdata;
        wStrb_r <= s_axi_wstrb;
      end
      // both halves present: commit and answer
      if (awHeld_r && wHeld_r) begin
        awHeld_r <= 1'b0;
        wHeld_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= (awAddr_r == `LGM_OFF_CTRL || awAddr_r == `LGM_OFF_SEGBASE) ? `LGM_RESP_OKAY : `LGM_RESP_SLVERR;
      end else if (bvalid_r && s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // software-written control and segment base, byte lanes honoured
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= `LGM_CTRL_RST;
      segBase_r <= `LGM_SEG_RST;
    end else if (awHeld_r && wHeld_r) begin
      for (int b = 0; b < 4; b++) begin
        if (wStrb_r[b] && awAddr_r == `LGM_OFF_CTRL) ctrl_r[8*b +: 8] <= wData_r[8*b +: 8];
        if (wStrb_r[b] && awAddr_r == `LGM_OFF_SEGBASE) segBase_r[8*b +: 8] <= wData_r[8*b +: 8];
      end
    end
  end

  // read channel; status shows mode, regime and stack pointer
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= `LGM_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_r <= 1'b1;
      rresp_r <= `LGM_RESP_OKAY;
      unique case (s_axi_araddr)
        `LGM_OFF_CTRL: rdata_r <= ctrl_r;
        `LGM_OFF_SEGBASE: rdata_r <= segBase_r;
        `LGM_OFF_STATUS: rdata_r <= {21'h0, topOfStack, segMode, 3'h0, legacy};
        default: begin
          rdata_r <= '0;
          rresp_r <= `LGM_RESP_SLVERR;
        end
      endcase
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // regime from mode, virtual-8086 and protection flags
  always_comb begin
    if (!legacy) segMode = LGM_SEG_NATIVE;
    else if (!ctrl_r[`LGM_CTRL_PE]) segMode = LGM_SEG_REAL;
    else if (ctrl_r[`LGM_CTRL_VM]) segMode = LGM_SEG_V86;
    else segMode = LGM_SEG_PROT;
  end

  // fetch width from default size; data width from default size or stack bit, flipped by prefix
  assign size32 = agFetch ? ctrl_r[`LGM_CTRL_CSIZE]
                          : ((ctrl_r[`LGM_CTRL_CSIZE] | ctrl_r[`LGM_CTRL_SBIG]) ^ ctrl_r[`LGM_CTRL_AOVR]);
  // base plus scaled index plus displacement; fetch uses pointer
  assign eaSum = agFetch ? agIp : (agBase + (agIndex << agScale) + agDisp);
  // starting address truncated to chosen width
  assign eaStart = size32 ? eaSum : {16'h0, eaSum[15:0]};
  // segment base added, kept to 32 bits
  assign vaStart = eaStart + segBase_r;

  // address results, registered
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      agValid <= 1'b0;
      agVa <= '0;
      agEndVa <= '0;
      agEndEa <= '0;
    end else begin
      agValid <= agReq;
      if (agReq && !legacy) begin
        agVa <= agNative;
        agEndVa <= agNative + {60'h0, agLen} - 64'h1;
        agEndEa <= '0;
      end else if (agReq) begin
        agVa <= {32'h0, vaStart};
        agEndVa <= {32'h0, vaStart + {28'h0, agLen} - 32'h1};
        // 16-bit end may pass 64K, 32-bit end wraps
        agEndEa <= size32 ? {1'b0, eaStart[15:0] + {12'h0, agLen} - 16'h1}
                          : {1'b0, eaStart[15:0]} + {13'h0, agLen} - 17'h1;
      end
    end
  end

  // aliased register file, native port and legacy writes
  always_ff @(posedge core_clk) begin
    if (nativeFpWr.en) fpFile[nativeFpWr.idx] <= nativeFpWr.val;
    // packed write sets sign and exponent to ones
    if (pkWrEn) fpFile[`LGM_PK_BASE + {2'h0, pkWrIdx}] <= {`LGM_PK_SE, pkWrData};
    // vector write pair, fixed exponent and clear sign
    if (vecWrEn) begin
      fpFile[`LGM_VEC_BASE + {1'b0, vecWrIdx, 1'b0}] <= {`LGM_VEC_SE, vecWrData[63:0]};
      fpFile[`LGM_VEC_BASE + {1'b0, vecWrIdx, 1'b1}] <= {`LGM_VEC_SE, vecWrData[127:64]};
    end
  end

  // stack slot i is packed register top+i
  assign stPhys = topOfStack + stRdIdx;

  // register reads and aliased writes toward the pipeline
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pkRdData <= '0;
      stRdData <= '0;
      vecRdData <= '0;
      nativeRdData <= '0;
      fpWrLo <= '0;
      fpWrHi <= '0;
    end else begin
      nativeRdData <= fpFile[nativeRdIdx];
      pkRdData <= fpFile[`LGM_PK_BASE + {2'h0, pkRdIdx}][63:0];
      stRdData <= fpFile[`LGM_PK_BASE + {2'h0, stPhys}][63:0];
      vecRdData <= {fpFile[`LGM_VEC_BASE + {1'b0, vecRdIdx, 1'b1}][63:0],
                    fpFile[`LGM_VEC_BASE + {1'b0, vecRdIdx, 1'b0}][63:0]};
      fpWrLo <= '0;
      fpWrHi <= '0;
      if (vecWrEn) begin
        // even low half, odd high half
        fpWrLo <= '{en: 1'b1, idx: `LGM_VEC_BASE + {1'b0, vecWrIdx, 1'b0}, val: {`LGM_VEC_SE, vecWrData[63:0]}};
        fpWrHi <= '{en: 1'b1, idx: `LGM_VEC_BASE + {1'b0, vecWrIdx, 1'b1}, val: {`LGM_VEC_SE, vecWrData[127:64]}};
      end else if (pkWrEn) begin
        fpWrLo <= '{en: 1'b1, idx: `LGM_PK_BASE + {2'h0, pkWrIdx}, val: {`LGM_PK_SE, pkWrData}};
      end
    end
  end

  // memory marking, byte order and cache coherence
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      memValid <= 1'b0;
      memOrd <= '0;
      memBusData <= '0;
      icacheInval <= 1'b0;
      icacheInvalAddr <= '0;
      icacheSync <= 1'b0;
      legacyPrev_r <= 1'b0;
    end else begin
      memValid <= memReq;
      legacyPrev_r <= legacy;
      // leaving legacy mode syncs the instruction cache
      icacheSync <= legacyPrev_r && !legacy;
      // legacy store flags a possible code change
      icacheInval <= memReq && memStore && legacy;
      if (memReq) icacheInvalAddr <= memAddr;
      if (memReq) memBusData <= (!legacy && ctrl_r[`LGM_CTRL_BIGEND]) ? {<<8{memWrData}} : memWrData;
      // legacy marks; fence on request or on a legacy locked access
      memOrd.acq <= memReq && legacy && (memLoad || memLocked);
      memOrd.rel <= memReq && legacy && (memStore || memLocked);
      memOrd.fence <= memReq && (memFenceReq || (legacy && memLocked));
    end
  end

  // checks
  property p_pk_wr;
    @(posedge core_clk) disable iff (!rst_n)
      pkWrEn && !vecWrEn |=> fpWrLo.en && fpWrLo.val[81:64] == 18'h3FFFF && fpWrLo.idx == 5'(8 + $past(pkWrIdx));
  endproperty
  a_pk_wr: assert property (p_pk_wr) else $error("packed write alias wrong");
  property p_vec_wr;
    @(posedge core_clk) disable iff (!rst_n)
      vecWrEn |=> fpWrHi.idx == fpWrLo.idx + 5'h1 && fpWrLo.idx == 5'(16 + 2 * $past(vecWrIdx))
                  && fpWrHi.val[81:64] == 18'h1003E && fpWrHi.val[63:0] == $past(vecWrData[127:64]);
  endproperty
  a_vec_wr: assert property (p_vec_wr) else $error("vector write alias wrong");
  property p_pk_rt;
    @(posedge core_clk) disable iff (!rst_n)
      pkWrEn && !nativeFpWr.en && !vecWrEn ##1 pkRdIdx == $past(pkWrIdx) && !pkWrEn |=> pkRdData == $past(pkWrData, 2);
  endproperty
  a_pk_rt: assert property (p_pk_rt) else $error("packed read not mantissa");
  property p_zext;
    @(posedge core_clk) disable iff (!rst_n) agReq && legacy |=> agVa[63:32] == 32'h0 && agEndVa[63:32] == 32'h0;
  endproperty
  a_zext: assert property (p_zext) else $error("legacy address not zero-extended");
  property p_segbase;
    @(posedge core_clk) disable iff (!rst_n)
      agReq && legacy && ctrl_r[`LGM_CTRL_CSIZE] && agFetch |=> agVa[31:0] == $past(agIp + segBase_r);
  endproperty
  a_segbase: assert property (p_segbase) else $error("segment base not applied");
  property p_le;
    @(posedge core_clk) disable iff (!rst_n) memReq && legacy |=> memBusData == $past(memWrData);
  endproperty
  a_le: assert property (p_le) else $error("legacy data byte swapped");
  property p_ord;
    @(posedge core_clk) disable iff (!rst_n)
      memReq && legacy && memStore && !memLoad && !memLocked |=> memOrd.rel && !memOrd.acq ##0 memValid;
  endproperty
  a_ord: assert property (p_ord) else $error("legacy store lacks release");
  property p_nofence;
    @(posedge core_clk) disable iff (!rst_n) $changed(legacy) && !memFenceReq && !memLocked |=> !memOrd.fence;
  endproperty
  a_nofence: assert property (p_nofence) else $error("fence added on switch");
  property p_sync;
    @(posedge core_clk) disable iff (!rst_n) $fell(legacy) |=> icacheSync ##1 !icacheSync;
  endproperty
  a_sync: assert property (p_sync) else $error("no cache sync on leaving legacy");
  property p_smc;
    @(posedge core_clk) disable iff (!rst_n) memReq && memStore && legacy |=> icacheInval && icacheInvalAddr == $past(memAddr);
  endproperty
  a_smc: assert property (p_smc) else $error("legacy store not flagged");
  c_vec: cover property (@(posedge core_clk) disable iff (!rst_n) vecWrEn ##1 fpWrHi.en);
  c_wrap: cover property (@(posedge core_clk) disable iff (!rst_n) agValid && agEndVa[31:0] < agVa[31:0]);
  c_switch: cover property (@(posedge core_clk) disable iff (!rst_n) icacheSync);
endmodule : lgm_compat

// file: tb/lgm_pipe_model.sv
/*
  partner model of the native pipeline: mirrors aliased fp writes and issues
  native fp writes on request.
  assumes fpWrLo/fpWrHi are one-cycle strobes on core_clk.
*/
`timescale 1ns/100ps
module lgm_pipe_model import lgm_pkg::*; (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire lgm_fpw_t fpWrLo,
  input wire lgm_fpw_t fpWrHi,
  input wire logic pokeEn,
  input wire logic [4:0] pokeIdx,
  input wire logic [81:0] pokeVal,
  input wire logic [4:0] mirIdx,
  output lgm_fpw_t nativeFpWr,
  output logic [81:0] mirVal
);
  // pipeline copy of the fp file
  logic [81:0] mirror_r [0:31];
  // native write, payload inverted when idle so stale data never looks valid
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      nativeFpWr <= '0;
    end else begin
      nativeFpWr <= '{en: pokeEn, idx: pokeIdx, val: pokeEn ? pokeVal : ~pokeVal};
    end
  end
  always_ff @(posedge core_clk) begin
    if (fpWrLo.en) begin
      mirror_r[fpWrLo.idx] <= fpWrLo.val;
    end
    if (fpWrHi.en) begin
      mirror_r[fpWrHi.idx] <= fpWrHi.val;
    end
  end
  assign mirVal = mirror_r[mirIdx];
endmodule : lgm_pipe_model

// file: tb/legacy_mode_state_and_addressing_tb.sv
/*
  self-checking bench for lgm_compat: registers, aliasing, addressing, ordering.
  assumes lgm_pipe_model on the native side and a 25 MHz core clock.
*/
`timescale 1ns/100ps
`include "lgm_defs.svh"
module legacy_mode_state_and_addressing_tb import lgm_pkg::*;;
  logic core_clk = 1'b0, rst_n = 1'b0;
  logic [11:0] awaddr = '0, araddr = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = '0, rdata;
  logic awready, wready, bvalid, arready, rvalid, agValid, memValid, icacheInval, icacheSync;
  logic [1:0] bresp, rresp;
  logic pkWrEn = 1'b0, vecWrEn = 1'b0, agReq = 1'b0, agFetch = 1'b0, pokeEn = 1'b0;
  logic memReq = 1'b0, memLoad = 1'b0, memStore = 1'b0, memLocked = 1'b0, memFenceReq = 1'b0;
  logic [2:0] pkWrIdx = '0, pkRdIdx = '0, stRdIdx = '0, vecWrIdx = '0, vecRdIdx = '0;
  logic [4:0] nativeRdIdx = '0, pokeIdx = '0, mirIdx = '0;
  logic [63:0] pkWrData = '0, pkRdData, stRdData, agNative = '0, agVa, agEndVa;
  logic [63:0] memWrData = '0, memAddr = '0, memBusData, icacheInvalAddr;
  logic [127:0] vecWrData = '0, vecRdData;
  logic [81:0] nativeRdData, pokeVal = '0, mirVal;
  logic [31:0] agBase = '0, agIndex = '0, agDisp = '0, agIp = '0;
  logic [1:0] agScale = '0;
  logic [3:0] agLen = 4'h1;
  logic [16:0] agEndEa;
  lgm_fpw_t nativeFpWr, fpWrLo, fpWrHi;
  lgm_mord_t memOrd;
  int fail_count = 0, n_tests = 0, syncSeen = 0;

  always #20 core_clk = ~core_clk;
  // count instruction cache sync pulses
  always @(posedge core_clk) if (icacheSync === 1'b1) syncSeen++;

  lgm_compat #(.ADDR_W(12)) i_dut (.core_clk(core_clk), .rst_n(rst_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .nativeFpWr(nativeFpWr), .nativeRdIdx(nativeRdIdx), .nativeRdData(nativeRdData),
    .pkWrEn(pkWrEn), .pkWrIdx(pkWrIdx), .pkWrData(pkWrData), .pkRdIdx(pkRdIdx), .pkRdData(pkRdData),
    .stRdIdx(stRdIdx), .stRdData(stRdData), .vecWrEn(vecWrEn), .vecWrIdx(vecWrIdx), .vecWrData(vecWrData),
    .vecRdIdx(vecRdIdx), .vecRdData(vecRdData), .fpWrLo(fpWrLo), .fpWrHi(fpWrHi), .agReq(agReq),
    .agFetch(agFetch), .agBase(agBase), .agIndex(agIndex), .agScale(agScale), .agDisp(agDisp), .agIp(agIp),
    .agLen(agLen), .agNative(agNative), .agValid(agValid), .agVa(agVa), .agEndVa(agEndVa), .agEndEa(agEndEa),
    .memReq(memReq), .memLoad(memLoad), .memStore(memStore), .memLocked(memLocked),
    .memFenceReq(memFenceReq), .memWrData(memWrData), .memAddr(memAddr), .memValid(memValid),
    .memOrd(memOrd), .memBusData(memBusData), .icacheInval(icacheInval),
    .icacheInvalAddr(icacheInvalAddr), .icacheSync(icacheSync));

  lgm_pipe_model i_pipe (.core_clk(core_clk), .rst_n(rst_n), .fpWrLo(fpWrLo), .fpWrHi(fpWrHi),
    .pokeEn(pokeEn), .pokeIdx(pokeIdx), .pokeVal(pokeVal), .mirIdx(mirIdx),
    .nativeFpWr(nativeFpWr), .mirVal(mirVal));

  // verdict and end of run
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : test_done

  task automatic chk(input string what, input logic [127:0] exp, input logic [127:0] got);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk

  // write: both halves offered, each dropped when taken, ends at bvalid
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    logic awr, wr, bv;
    logic [1:0] rs;
    bv = 1'b0;
    @(posedge core_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int i = 0; i < 40 && !bv; i++) begin
      @(negedge core_clk);
      awr = awready;
      wr = wready;
      bv = bvalid;
      rs = bresp;
      @(posedge core_clk);
      if (awr) awvalid <= 1'b0;
      if (wr) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    if (!bv) begin
      fail_count++;
      test_done();
    end
    chk("bresp", er, rs);
  endtask : axi_wr

  // read: arvalid held until taken, rready held until rvalid
  task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, input logic [1:0] er);
    logic arr, rv;
    logic [1:0] rs;
    rv = 1'b0;
    @(posedge core_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int i = 0; i < 40 && !rv; i++) begin
      @(negedge core_clk);
      arr = arready;
      rv = rvalid;
      d = rdata;
      rs = rresp;
      @(posedge core_clk);
      if (arr) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    if (!rv) begin
      fail_count++;
      test_done();
    end
    chk("rresp", er, rs);
  endtask : axi_rd

  task automatic t_regs;
    logic [31:0] d;
    logic [31:0] ctl [4] = '{32'h1, 32'h5, 32'h7, 32'h0};
    logic [3:0] reg_exp [4] = '{4'h2, 4'h8, 4'h4, 4'h1};
    axi_rd(`LGM_OFF_CTRL, d, `LGM_RESP_OKAY);
    chk("ctrl reset", `LGM_CTRL_RST, d);
    axi_wr(`LGM_OFF_STATUS, 32'hFFFF_FFFF, `LGM_RESP_SLVERR);
    axi_rd(12'h00C, d, `LGM_RESP_SLVERR);
    for (int k = 0; k < 4; k++) begin
      axi_wr(`LGM_OFF_CTRL, ctl[k] | 32'h500, `LGM_RESP_OKAY);
      axi_rd(`LGM_OFF_STATUS, d, `LGM_RESP_OKAY);
      chk("seg regime", {3'h5, reg_exp[k], 3'h0, ctl[k][0]}, d[10:0]);
    end
  endtask : t_regs

  task automatic poke(input logic [4:0] i, input logic [81:0] v);
    @(posedge core_clk);
    pokeEn <= 1'b1;
    pokeIdx <= i;
    pokeVal <= v;
    @(posedge core_clk);
    pokeEn <= 1'b0;
    repeat (2) @(posedge core_clk);
  endtask : poke

  task automatic t_alias;
    axi_wr(`LGM_OFF_CTRL, 32'h301, `LGM_RESP_OKAY);
    poke(5'h08, {1'b0, 17'h1FFFE, 64'h0BAD_F00D_0000_0001});
    poke(5'h10, {1'b1, 17'h1FFFE, 64'h1111_2222_3333_4444});
    pkWrEn <= 1'b1;
    pkWrIdx <= 3'h7;
    pkWrData <= 64'hA5A5_0000_1234_FFFF;
    @(posedge core_clk);
    pkWrEn <= 1'b0;
    pkRdIdx <= 3'h7;
    mirIdx <= 5'h0F;
    @(negedge core_clk);
    chk("fpWrLo", {1'b1, 5'h0F, 18'h3FFFF, 64'hA5A5_0000_1234_FFFF}, fpWrLo);
    @(posedge core_clk);
    pkRdIdx <= 3'h0;
    stRdIdx <= 3'h5;
    @(negedge core_clk);
    chk("pkRdData", 64'hA5A5_0000_1234_FFFF, pkRdData);
    chk("mirror", {18'h3FFFF, 64'hA5A5_0000_1234_FFFF}, mirVal);
    @(posedge core_clk);
    vecWrEn <= 1'b1;
    vecWrIdx <= 3'h7;
    vecWrData <= {64'hFEDC_BA98_7654_3210, 64'h0123_4567_89AB_CDEF};
    vecRdIdx <= 3'h0;
    @(negedge core_clk);
    chk("pk not_a_value_encoding", 64'h0BAD_F00D_0000_0001, pkRdData);
    chk("stack view", 64'h0BAD_F00D_0000_0001, stRdData);
    chk("vec not_a_value_encoding lo", 64'h1111_2222_3333_4444, vecRdData[63:0]);
    @(posedge core_clk);
    vecWrEn <= 1'b0;
    vecRdIdx <= 3'h7;
    nativeRdIdx <= 5'h1F;
    @(negedge core_clk);
    chk("fpWrLo vec", {1'b1, 5'h1E, 18'h1003E, 64'h0123_4567_89AB_CDEF}, fpWrLo);
    chk("fpWrHi vec", {1'b1, 5'h1F, 18'h1003E, 64'hFEDC_BA98_7654_3210}, fpWrHi);
    @(negedge core_clk);
    chk("vecRdData", {64'hFEDC_BA98_7654_3210, 64'h0123_4567_89AB_CDEF}, vecRdData);
    chk("native fp31", {18'h1003E, 64'hFEDC_BA98_7654_3210}, nativeRdData);
  endtask : t_alias

  // one address request with fixed scale, checked a cycle later
  task automatic ag(input logic f, input logic [31:0] b, input logic [31:0] x, input logic [31:0] dp,
                    input logic [31:0] ip, input logic [3:0] ln, input logic [63:0] va, input logic [63:0] ev);
    @(posedge core_clk);
    agReq <= 1'b1;
    agFetch <= f;
    agBase <= b;
    agIndex <= x;
    agScale <= 2'h1;
    agDisp <= dp;
    agIp <= ip;
    agLen <= ln;
    agNative <= 64'hFFFF_0000_1234_5678;
    @(posedge core_clk);
    agReq <= 1'b0;
    @(negedge core_clk);
    chk("agValid", 1'b1, agValid);
    chk("agVa", va, agVa);
    chk("agEndVa", ev, agEndVa);
  endtask : ag

  task automatic t_addr;
    axi_wr(`LGM_OFF_SEGBASE, 32'h0010_0000, `LGM_RESP_OKAY);
    axi_wr(`LGM_OFF_CTRL, 32'h1, `LGM_RESP_OKAY);
    ag(1'b0, 32'h1234_FFF0, 32'h4, 32'h6, 32'h0, 4'h4, 64'h0010_FFFE, 64'h0011_0001);
    chk("agEndEa 16", 17'h10001, agEndEa);
    axi_wr(`LGM_OFF_CTRL, 32'h11, `LGM_RESP_OKAY);
    ag(1'b0, 32'hFFEF_FFF0, 32'h2, 32'h8, 32'h0, 4'h8, 64'hFFFF_FFFC, 64'h3);
    ag(1'b1, 32'h0, 32'h0, 32'h0, 32'h0001_FFFF, 4'h2, 64'h0010_FFFF, 64'h0011_0000);
    chk("agEndEa fetch", 17'h10000, agEndEa);
    // 32-bit fetch: pointer plus base wraps in 32 bits, low 16 bits of the end offset wrap
    axi_wr(`LGM_OFF_CTRL, 32'h9, `LGM_RESP_OKAY);
    ag(1'b1, 32'h0, 32'h0, 32'h0, 32'hFFFF_FFFE, 4'h4, 64'h000F_FFFE, 64'h0010_0001);
    chk("agEndEa fetch 32", 17'h00001, agEndEa);
    axi_wr(`LGM_OFF_CTRL, 32'h0, `LGM_RESP_OKAY);
    ag(1'b0, 32'h0, 32'h0, 32'h0, 32'h0, 4'h4, 64'hFFFF_0000_1234_5678, 64'hFFFF_0000_1234_567B);
  endtask : t_addr

  task automatic mem(input logic [3:0] k, input logic [2:0] ord, input logic [63:0] bd, input logic inv);
    @(posedge core_clk);
    memReq <= 1'b1;
    {memLoad, memStore, memLocked, memFenceReq} <= k;
    memWrData <= 64'h0102_0304_0506_0708;
    memAddr <= 64'h0000_0000_0040_1000;
    @(posedge core_clk);
    memReq <= 1'b0;
    @(negedge core_clk);
    chk("memValid", 1'b1, memValid);
    chk("memOrd", ord, memOrd);
    chk("memBusData", bd, memBusData);
    chk("icacheInval", inv, icacheInval);
    if (inv) chk("icacheInvalAddr", 64'h0040_1000, icacheInvalAddr);
  endtask : mem

  task automatic t_mem;
    int s0;
    // earlier scenarios already left legacy mode; count from here on
    s0 = syncSeen;
    axi_wr(`LGM_OFF_CTRL, 32'h41, `LGM_RESP_OKAY);
    repeat (3) @(posedge core_clk);
    chk("no sync on entry", s0, syncSeen);
    mem(4'h4, 3'b010, 64'h0102_0304_0506_0708, 1'b1);
    mem(4'h8, 3'b100, 64'h0102_0304_0506_0708, 1'b0);
    mem(4'h2, 3'b111, 64'h0102_0304_0506_0708, 1'b0);
    axi_wr(`LGM_OFF_CTRL, 32'h40, `LGM_RESP_OKAY);
    for (int i = 0; i < 10 && syncSeen == s0; i++) @(posedge core_clk);
    chk("sync on exit", s0 + 1, syncSeen);
    mem(4'h4, 3'b000, 64'h0807_0605_0403_0201, 1'b0);
    mem(4'h9, 3'b001, 64'h0807_0605_0403_0201, 1'b0);
  endtask : t_mem

  initial begin
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    t_regs();
    t_alias();
    t_addr();
    t_mem();
    test_done();
  end
endmodule : legacy_mode_state_and_addressing_tb
